// ---- hw/tps_pkg.sv ----
// Constants, types and register map for the shared timer prescaler block.
// Assumes one 10 MHz system clock and a plain single-cycle register port.
package tps_pkg;

  // Register offsets
  localparam logic [3:0] OFS_FLAGS = 4'h0;
  localparam logic [3:0] OFS_SFIO = 4'h1;
  localparam logic [3:0] OFS_IRQ_ENABLE = 4'h2;
  localparam logic [3:0] OFS_CLOCK_SELECT = 4'h3;
  localparam logic [3:0] OFS_COMPARE = 4'h4;
  localparam logic [3:0] OFS_COUNT = 4'h5;

  // Field positions
  localparam int BIT_OVERFLOW = 0;
  localparam int BIT_COMPARE = 1;
  localparam int BIT_PSR = 0;
  localparam int BIT_SFIO_RO = 4;
  localparam int CS_T0_LSB = 0;
  localparam int CS_T1_LSB = 4;

  // Reset values
  localparam logic [7:0] RST_FLAGS = 8'h00;
  localparam logic [7:0] RST_SFIO = 8'h00;
  localparam logic [7:0] RST_IRQ_ENABLE = 8'h00;
  localparam logic [7:0] RST_CLOCK_SELECT = 8'h00;
  localparam logic [7:0] RST_COMPARE = 8'h00;

  // Clock select codes
  localparam logic [2:0] CS_STOP = 3'h0;
  localparam logic [2:0] CS_DIRECT = 3'h1;
  localparam logic [2:0] CS_DIV8 = 3'h2;
  localparam logic [2:0] CS_DIV64 = 3'h3;
  localparam logic [2:0] CS_DIV256 = 3'h4;
  localparam logic [2:0] CS_DIV1024 = 3'h5;
  localparam logic [2:0] CS_EXT_FALL = 3'h6;
  localparam logic [2:0] CS_EXT_RISE = 3'h7;

  // Prescaler tap widths and timer count
  localparam int PRESCALE_BITS = 10;
  localparam int TAP8_BITS = 3;
  localparam int TAP64_BITS = 6;
  localparam int TAP256_BITS = 8;
  localparam int TIMERS = 2;

  typedef struct packed {
    logic [3:0] addr;
    logic [7:0] wdata;
    logic write;
    logic read;
  } tps_bus_req_type;

  // Events from timer 0's counter, same clock domain
  typedef struct packed {
    logic [7:0] count;
    logic overflow;
    logic bottom_turn;
    logic phase_correct;
  } tps_t0_state_type;

endpackage

// ---- hw/tps_timer_prescaler.sv ----
// Shared prescaler, clock-source select, count-pin sync and timer 0 flags.
// Assumes counters outside consume timer_tick pulses and report events back.
module tps_timer_prescaler (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic reset,
  // Register port
  input wire tps_pkg::tps_bus_req_type bus_req,
  output logic [7:0] reg_rdata,
  // External count pins, index 0 for timer 0
  input wire logic [1:0] external_count_pin,
  // Processor side
  input wire logic global_irq_enable,
  input wire logic t0_overflow_vector_taken,
  input wire logic t0_compare_vector_taken,
  // Timer 0 counter feedback
  input wire tps_pkg::tps_t0_state_type t0_state,
  // Timer clocks and interrupt requests
  output logic [1:0] timer_tick,
  output logic t0_overflow_irq,
  output logic t0_compare_irq
);

  logic [7:0] timer_interrupt_flags;
  logic [7:0] special_function_io;
  logic [7:0] irq_enable;
  logic [7:0] clock_select_reg;
  logic [7:0] t0_compare_value;
  logic shared_prescaler_reset;
  logic [tps_pkg::PRESCALE_BITS-1:0] prescale_count;
  logic tap8;
  logic tap64;
  logic tap256;
  logic tap1024;
  logic [1:0] pin_meta;
  logic [1:0] pin_sync;
  logic [1:0] pin_prev;
  logic [1:0] pin_rise;
  logic [1:0] pin_fall;
  logic wr_flags;
  logic ovf_set;
  logic cmp_set;
  logic ovf_clear;
  logic cmp_clear;
  logic t0_overflow_irq_enable;
  logic t0_compare_irq_enable;

  assign wr_flags = bus_req.write && (bus_req.addr == tps_pkg::OFS_FLAGS);
  assign t0_overflow_irq_enable = irq_enable[tps_pkg::BIT_OVERFLOW];
  assign t0_compare_irq_enable = irq_enable[tps_pkg::BIT_COMPARE];

  // Plain control registers; the reset bit lives apart since it self-clears
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      special_function_io <= tps_pkg::RST_SFIO;
      irq_enable <= tps_pkg::RST_IRQ_ENABLE;
      clock_select_reg <= tps_pkg::RST_CLOCK_SELECT;
      t0_compare_value <= tps_pkg::RST_COMPARE;
    end else if (bus_req.write) begin
      case (bus_req.addr)
        tps_pkg::OFS_SFIO: begin
          special_function_io <= bus_req.wdata;
        end
        tps_pkg::OFS_IRQ_ENABLE: begin
          irq_enable <= bus_req.wdata & 8'h03;
        end
        tps_pkg::OFS_CLOCK_SELECT: begin
          clock_select_reg <= bus_req.wdata & 8'h77; // Two independent select fields
        end
        tps_pkg::OFS_COMPARE: begin
          t0_compare_value <= bus_req.wdata;
        end
        default: begin
        end
      endcase
    end
  end

  // Prescaler reset request, one cycle, then gone
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      shared_prescaler_reset <= 1'b0;
    end else begin
      shared_prescaler_reset <= bus_req.write && (bus_req.addr == tps_pkg::OFS_SFIO)
                                && bus_req.wdata[tps_pkg::BIT_PSR];
    end
  end

  // Free-running divider shared by both timers; reset hits both phases
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      prescale_count <= '0;
    end else if (shared_prescaler_reset) begin
      prescale_count <= '0;
    end else begin
      prescale_count <= prescale_count + 1'b1;
    end
  end

  // Tap pulses on the last count of each divide period
  assign tap8 = &prescale_count[tps_pkg::TAP8_BITS-1:0];
  assign tap64 = &prescale_count[tps_pkg::TAP64_BITS-1:0];
  assign tap256 = &prescale_count[tps_pkg::TAP256_BITS-1:0];
  assign tap1024 = &prescale_count;

  // Count pins: two flops stand in for the latch plus sync register
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      pin_meta <= 2'h0;
      pin_sync <= 2'h0;
      pin_prev <= 2'h0;
    end else begin
      pin_meta <= external_count_pin;
      pin_sync <= pin_meta;
      pin_prev <= pin_sync;
    end
  end

  assign pin_rise = pin_sync & ~pin_prev;
  assign pin_fall = ~pin_sync & pin_prev;

  // Per-timer source select; the pin path skips the divider entirely
  genvar t;
  generate
    for (t = 0; t < tps_pkg::TIMERS; t++) begin : g_tick
      logic [2:0] cs;
      assign cs = clock_select_reg[t*4 +: 3];
      always_ff @(posedge sys_clk) begin
        if (reset) begin
          timer_tick[t] <= 1'b0;
        end else begin
          case (cs)
            tps_pkg::CS_STOP: timer_tick[t] <= 1'b0;
            tps_pkg::CS_DIRECT: timer_tick[t] <= 1'b1;
            tps_pkg::CS_DIV8: timer_tick[t] <= tap8;
            tps_pkg::CS_DIV64: timer_tick[t] <= tap64;
            tps_pkg::CS_DIV256: timer_tick[t] <= tap256;
            tps_pkg::CS_DIV1024: timer_tick[t] <= tap1024;
            tps_pkg::CS_EXT_FALL: timer_tick[t] <= pin_fall[t];
            tps_pkg::CS_EXT_RISE: timer_tick[t] <= pin_rise[t];
            default: timer_tick[t] <= 1'b0;
          endcase
        end
      end
    end
  endgenerate

  // Timer 0 flag events
  assign ovf_set = t0_state.phase_correct ? t0_state.bottom_turn : t0_state.overflow;
  assign cmp_set = timer_tick[0] && (t0_state.count == t0_compare_value);
  assign ovf_clear = t0_overflow_vector_taken || (wr_flags && bus_req.wdata[tps_pkg::BIT_OVERFLOW]);
  assign cmp_clear = t0_compare_vector_taken || (wr_flags && bus_req.wdata[tps_pkg::BIT_COMPARE]);

  // Flags: a set in the clearing cycle survives so no event is dropped
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      timer_interrupt_flags <= tps_pkg::RST_FLAGS;
    end else begin
      if (ovf_set) begin
        timer_interrupt_flags[tps_pkg::BIT_OVERFLOW] <= 1'b1;
      end else if (ovf_clear) begin
        timer_interrupt_flags[tps_pkg::BIT_OVERFLOW] <= 1'b0;
      end
      if (cmp_set) begin
        timer_interrupt_flags[tps_pkg::BIT_COMPARE] <= 1'b1;
      end else if (cmp_clear) begin
        timer_interrupt_flags[tps_pkg::BIT_COMPARE] <= 1'b0;
      end
    end
  end

  // Interrupt requests, registered so outputs come from flops
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      t0_overflow_irq <= 1'b0;
      t0_compare_irq <= 1'b0;
    end else begin
      t0_overflow_irq <= global_irq_enable && t0_overflow_irq_enable
                         && timer_interrupt_flags[tps_pkg::BIT_OVERFLOW];
      t0_compare_irq <= global_irq_enable && t0_compare_irq_enable
                        && timer_interrupt_flags[tps_pkg::BIT_COMPARE];
    end
  end

  // Read data one cycle after the strobe; unmapped offsets read zero
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      reg_rdata <= 8'h00;
    end else if (bus_req.read) begin
      case (bus_req.addr)
        tps_pkg::OFS_FLAGS: reg_rdata <= timer_interrupt_flags;
        tps_pkg::OFS_SFIO: reg_rdata <= special_function_io & 8'hee;
        tps_pkg::OFS_IRQ_ENABLE: reg_rdata <= irq_enable;
        tps_pkg::OFS_CLOCK_SELECT: reg_rdata <= clock_select_reg;
        tps_pkg::OFS_COMPARE: reg_rdata <= t0_compare_value;
        tps_pkg::OFS_COUNT: reg_rdata <= t0_state.count;
        default: reg_rdata <= 8'h00;
      endcase
    end else begin
      reg_rdata <= 8'h00;
    end
  end

  default clocking @(posedge sys_clk); endclocking
  default disable iff (reset);

  a_ovf_irq_gate: assert property (
    (global_irq_enable && t0_overflow_irq_enable && timer_interrupt_flags[0]) |=> t0_overflow_irq)
    else $error("overflow irq not raised");
  a_ovf_irq_quiet: assert property (
    !timer_interrupt_flags[0] |=> !t0_overflow_irq)
    else $error("overflow irq without flag");
  a_cmp_flag_set: assert property (
    (timer_tick[0] && t0_state.count == t0_compare_value) |=> timer_interrupt_flags[1])
    else $error("compare flag missed");
  a_cmp_irq_gate: assert property (
    (global_irq_enable && t0_compare_irq_enable && timer_interrupt_flags[1]) |=> t0_compare_irq)
    else $error("compare irq not raised");
  a_vector_clears: assert property (
    (t0_overflow_vector_taken && !ovf_set) |=> !timer_interrupt_flags[0])
    else $error("vector did not clear flag");
  a_zero_write_keeps: assert property (
    (wr_flags && !bus_req.wdata[1] && timer_interrupt_flags[1] && !t0_compare_vector_taken)
    |=> timer_interrupt_flags[1])
    else $error("zero write cleared flag");
  a_set_beats_clear: assert property (
    (ovf_set && ovf_clear) |=> timer_interrupt_flags[0])
    else $error("set lost to clear");
  a_direct_tick: assert property (
    (clock_select_reg[2:0] == 3'h1) [*2] |-> timer_tick[0])
    else $error("direct select not ticking");
  a_stop_no_tick: assert property (
    (clock_select_reg[2:0] == 3'h0) |=> !timer_tick[0])
    else $error("stopped timer ticked");
  a_psr_restart: assert property (
    (bus_req.write && bus_req.addr == 4'h1 && bus_req.wdata[0])
    |=> shared_prescaler_reset ##1 (!shared_prescaler_reset && prescale_count == 10'h000))
    else $error("prescaler reset not done");
  a_psr_reads_zero: assert property (
    (bus_req.read && bus_req.addr == 4'h1) |=> !reg_rdata[0])
    else $error("reset bit read as one");
  a_ext_rise_tick: assert property (
    ($rose(external_count_pin[0]) && clock_select_reg[2:0] == 3'h7) [*1] ##1
    (clock_select_reg[2:0] == 3'h7) [*2] |=> timer_tick[0])
    else $error("pin edge not ticked in time");

  // Flag clearing paths; each one gated so a same-cycle set wins
  a_cmp_vec_clears: assert property (
    (t0_compare_vector_taken && !cmp_set) |=> !timer_interrupt_flags[1])
    else $error("compare vector did not clear flag");
  a_ovf_one_clears: assert property (
    (wr_flags && bus_req.wdata[0] && !ovf_set) |=> !timer_interrupt_flags[0])
    else $error("overflow one write did not clear");
  a_cmp_one_clears: assert property (
    (wr_flags && bus_req.wdata[1] && !cmp_set) |=> !timer_interrupt_flags[1])
    else $error("compare one write did not clear");
  a_ovf_zero_keeps: assert property (
    (wr_flags && !bus_req.wdata[0] && timer_interrupt_flags[0] && !t0_overflow_vector_taken)
    |=> timer_interrupt_flags[0])
    else $error("zero write cleared overflow");
  a_ovf_flag_hold: assert property (
    (!ovf_set && !ovf_clear) |=> $stable(timer_interrupt_flags[0]))
    else $error("overflow flag moved on its own");
  a_cmp_set_beats: assert property (
    (cmp_set && cmp_clear) |=> timer_interrupt_flags[1])
    else $error("compare set lost to clear");

  // Flag sources; phase correct mode swaps the overflow event
  a_ovf_flag_set: assert property (
    (!t0_state.phase_correct && t0_state.overflow) |=> timer_interrupt_flags[0])
    else $error("overflow flag missed");
  a_bottom_flag_set: assert property (
    (t0_state.phase_correct && t0_state.bottom_turn) |=> timer_interrupt_flags[0])
    else $error("bottom turn flag missed");
  a_pc_ovf_ignored: assert property (
    (t0_state.phase_correct && !t0_state.bottom_turn && !timer_interrupt_flags[0] && !ovf_clear)
    |=> !timer_interrupt_flags[0])
    else $error("overflow flag set in phase correct");
  a_cmp_needs_tick: assert property (
    (!timer_tick[0] && !timer_interrupt_flags[1]) |=> !timer_interrupt_flags[1])
    else $error("compare flag without tick");

  // Requests vanish once the flag clears or the global enable drops
  a_cmp_irq_quiet: assert property (
    !timer_interrupt_flags[1] |=> !t0_compare_irq)
    else $error("compare irq without flag");
  a_cmp_irq_off_gie: assert property (
    !global_irq_enable |=> !t0_compare_irq)
    else $error("compare irq with global off");
  a_ovf_irq_off_gie: assert property (
    !global_irq_enable |=> !t0_overflow_irq)
    else $error("overflow irq with global off");

  // Divider phase and the self-clearing reset pulse
  a_psr_count_restart: assert property (
    shared_prescaler_reset |=> prescale_count == 10'h000)
    else $error("divider not restarted");
  a_prescale_runs: assert property (
    !shared_prescaler_reset |=> prescale_count == $past(prescale_count) + 10'h001)
    else $error("divider not free running");
  a_psr_one_cycle: assert property (
    (shared_prescaler_reset && !(bus_req.write && bus_req.addr == 4'h1 && bus_req.wdata[0]))
    |=> !shared_prescaler_reset)
    else $error("reset bit did not self clear");
  a_psr_zero_write: assert property (
    (bus_req.write && bus_req.addr == 4'h1 && !bus_req.wdata[0]) |=> !shared_prescaler_reset)
    else $error("zero write reset the divider");

  // Tap selection, checked at both ends of the tap range
  a_tap8_tick: assert property (
    (clock_select_reg[2:0] == 3'h2 && (&prescale_count[2:0])) |=> timer_tick[0])
    else $error("divide by 8 tick missed");
  a_tap8_gap: assert property (
    (clock_select_reg[2:0] == 3'h2 && !(&prescale_count[2:0])) |=> !timer_tick[0])
    else $error("divide by 8 ticked early");
  a_tap1024_tick: assert property (
    (clock_select_reg[6:4] == 3'h5 && (&prescale_count)) |=> timer_tick[1])
    else $error("divide by 1024 tick missed");
  a_tap1024_gap: assert property (
    (clock_select_reg[6:4] == 3'h5 && !(&prescale_count)) |=> !timer_tick[1])
    else $error("divide by 1024 ticked early");
  a_direct_tick1: assert property (
    (clock_select_reg[6:4] == 3'h1) [*2] |-> timer_tick[1])
    else $error("timer 1 direct not ticking");
  a_stop_no_tick1: assert property (
    (clock_select_reg[6:4] == 3'h0) |=> !timer_tick[1])
    else $error("stopped timer 1 ticked");

  // Pin edges pass straight through, never through the divider
  a_ext_fall_tick: assert property (
    (clock_select_reg[2:0] == 3'h6 && pin_fall[0]) |=> timer_tick[0])
    else $error("falling edge not ticked");
  a_ext_no_prescale: assert property (
    (clock_select_reg[2:0] == 3'h7 && !pin_rise[0]) |=> !timer_tick[0])
    else $error("pin mode ticked without edge");
  a_ext1_rise_tick: assert property (
    (clock_select_reg[6:4] == 3'h7 && pin_rise[1]) |=> timer_tick[1])
    else $error("timer 1 rising edge not ticked");

  // Read data stands one cycle only, zero otherwise
  a_rdata_idle: assert property (
    !bus_req.read |=> reg_rdata == 8'h00)
    else $error("read data outside its cycle");

endmodule

// ---- dv/tps_pin_source.sv ----
// Partner model: external square wave source on both count pins.
// Assumes the bench raises run only while the pins are low and idle.
module tps_pin_source #(
  parameter int HALF_NS = 250
) (
  // Channel run requests
  input wire logic [1:0] run,
  // Count pins
  output logic [1:0] pin
);
  timeunit 1ns;
  timeprecision 1ns;

  // Full period always finished, so a stopped channel rests low
  initial begin
    pin = 2'h0;
    forever begin
      wait (|run);
      #(HALF_NS) pin = run;
      #(HALF_NS) pin = 2'h0;
    end
  end
endmodule

// ---- dv/timer_prescaler_extclk_flags_tb.sv ----
// Self-checking bench for the shared prescaler, count pins and timer 0 flags.
// Assumes the design package is compiled first and the pin model beside it.
module timer_prescaler_extclk_flags_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic sys_clk, reset, gie, ovf_taken, cmp_taken, rd_wait;
  tps_pkg::tps_bus_req_type bus_req;
  tps_pkg::tps_t0_state_type t0_state;
  logic [7:0] reg_rdata, v;
  logic [1:0] pin, run, timer_tick;
  logic t0_overflow_irq, t0_compare_irq;
  logic [7:0] exp_q [$];
  int fail_count, checked, a0, a1, e0, e1, d0, d1, f0, f1;
  int ticks [2];
  int edges [2];
  int sh [4] = '{3, 6, 8, 10};

  tps_timer_prescaler tps_timer_prescaler_i (.sys_clk(sys_clk), .reset(reset), .bus_req(bus_req),
    .reg_rdata(reg_rdata), .external_count_pin(pin), .global_irq_enable(gie),
    .t0_overflow_vector_taken(ovf_taken), .t0_compare_vector_taken(cmp_taken), .t0_state(t0_state),
    .timer_tick(timer_tick), .t0_overflow_irq(t0_overflow_irq), .t0_compare_irq(t0_compare_irq));
  tps_pin_source tps_pin_source_i (.run(run), .pin(pin));

  // Clock, 100 ns period
  initial begin
    sys_clk = 1'b0;
    forever #50 sys_clk = ~sys_clk;
  end

  task test_done;
    if (fail_count == 0 && checked > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  task chk(input logic [15:0] exp, input logic [15:0] got);
    checked++;
    if (got !== exp) begin
      fail_count++;
      $display("unexpected at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask

  task cyc(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask

  task wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    bus_req <= '{addr: a, wdata: d, write: 1'b1, read: 1'b0};
    @(posedge sys_clk);
    bus_req.write <= 1'b0;
  endtask

  // Expected read data noted when the strobe goes out
  task rd(input logic [3:0] a, input logic [7:0] e);
    @(posedge sys_clk);
    bus_req <= '{addr: a, wdata: 8'h00, write: 1'b0, read: 1'b1};
    exp_q.push_back(e);
    @(posedge sys_clk);
    bus_req.read <= 1'b0;
  endtask

  // Cycles from a prescaler reset to each timer's first tick
  task psr_delays(output int p0, output int p1);
    wr(tps_pkg::OFS_SFIO, 8'h01);
    p0 = 0;
    p1 = 0;
    for (int k = 1; k < 600 && (p0 == 0 || p1 == 0); k++) begin
      cyc(1);
      if (k > 3 && timer_tick[0] === 1'b1 && p0 == 0) p0 = k;
      if (k > 3 && timer_tick[1] === 1'b1 && p1 == 0) p1 = k;
    end
  endtask

  // Output watcher: read data against oldest note, tick counting
  always @(posedge sys_clk) begin
    if (rd_wait && exp_q.size() > 0) chk({8'h00, exp_q.pop_front()}, {8'h00, reg_rdata});
    rd_wait <= bus_req.read;
    if (timer_tick[0] === 1'b1) ticks[0]++;
    if (timer_tick[1] === 1'b1) ticks[1]++;
  end
  always @(posedge pin[0]) edges[0]++;
  always @(negedge pin[1]) edges[1]++;

  // Hang guard, roughly three times the expected run
  initial begin
    #3000000;
    fail_count++;
    test_done;
  end

  initial begin
    reset = 1'b1; bus_req = '0; run = 2'h0; gie = 1'b0; ovf_taken = 1'b0; cmp_taken = 1'b0;
    t0_state = '0; rd_wait = 1'b0; fail_count = 0; checked = 0; ticks = '{0, 0}; edges = '{0, 0};
    void'($urandom(48225));
    cyc(16);
    reset <= 1'b0;
    rd(tps_pkg::OFS_FLAGS, 8'h00);
    wr(tps_pkg::OFS_SFIO, 8'hff);
    rd(tps_pkg::OFS_SFIO, 8'hee);
    rd(4'hf, 8'h00);
    // Direct clock on timer 0, timer 1 stopped
    wr(tps_pkg::OFS_CLOCK_SELECT, {1'b0, tps_pkg::CS_STOP, 1'b0, tps_pkg::CS_DIRECT});
    cyc(2); a0 = ticks[0]; a1 = ticks[1]; cyc(40);
    chk(16'(40), 16'(ticks[0] - a0));
    chk(16'(0), 16'(ticks[1] - a1));
    // Every tap, the two timers on different taps
    for (int c = 2; c <= 5; c++) begin
      wr(tps_pkg::OFS_CLOCK_SELECT, {1'b0, 3'(7 - c), 1'b0, 3'(c)});
      cyc(4); a0 = ticks[0]; a1 = ticks[1]; cyc(2048);
      chk(16'(2048 >> sh[c - 2]), 16'(ticks[0] - a0));
      chk(16'(2048 >> sh[7 - c - 2]), 16'(ticks[1] - a1));
    end
    // Prescaler reset restarts both phases together
    wr(tps_pkg::OFS_CLOCK_SELECT, {1'b0, tps_pkg::CS_DIV256, 1'b0, tps_pkg::CS_DIV64});
    psr_delays(d0, d1);
    cyc($urandom_range(300, 1));
    psr_delays(f0, f1);
    chk(16'(d0), 16'(f0));
    chk(16'(192), 16'(f1 - f0));
    // Count pins, select changed only while pins rest low
    wr(tps_pkg::OFS_CLOCK_SELECT, {1'b0, tps_pkg::CS_EXT_FALL, 1'b0, tps_pkg::CS_EXT_RISE});
    cyc(3); a0 = ticks[0]; a1 = ticks[1]; e0 = edges[0]; e1 = edges[1];
    run = 2'h3; cyc(200); run = 2'h0; cyc(20);
    chk(16'(edges[0] - e0), 16'(ticks[0] - a0));
    chk(16'(edges[1] - e1), 16'(ticks[1] - a1));
    // Timer 0 flags and requests
    wr(tps_pkg::OFS_CLOCK_SELECT, {1'b0, tps_pkg::CS_STOP, 1'b0, tps_pkg::CS_DIRECT});
    v = 8'($urandom_range(255));
    wr(tps_pkg::OFS_COMPARE, v);
    t0_state.count <= v + 8'h01; cyc(3);
    wr(tps_pkg::OFS_FLAGS, 8'h03);
    rd(tps_pkg::OFS_FLAGS, 8'h00);
    t0_state.count <= v; cyc(2); t0_state.count <= v + 8'h01;
    rd(tps_pkg::OFS_FLAGS, 8'h02);
    wr(tps_pkg::OFS_IRQ_ENABLE, 8'h03); gie <= 1'b1; cyc(3);
    chk(16'h0001, {14'h0, t0_overflow_irq, t0_compare_irq});
    t0_state.overflow <= 1'b1; cyc(1); t0_state.overflow <= 1'b0; cyc(3);
    chk(16'h0003, {14'h0, t0_overflow_irq, t0_compare_irq});
    gie <= 1'b0; cyc(3);
    chk(16'h0000, {14'h0, t0_overflow_irq, t0_compare_irq});
    wr(tps_pkg::OFS_FLAGS, 8'h00);
    rd(tps_pkg::OFS_FLAGS, 8'h03);
    wr(tps_pkg::OFS_FLAGS, 8'h01);
    rd(tps_pkg::OFS_FLAGS, 8'h02);
    cmp_taken <= 1'b1; cyc(1); cmp_taken <= 1'b0;
    rd(tps_pkg::OFS_FLAGS, 8'h00);
    // Overflow lands in the same cycle as its clearing write
    @(posedge sys_clk);
    bus_req <= '{addr: tps_pkg::OFS_FLAGS, wdata: 8'h01, write: 1'b1, read: 1'b0};
    t0_state.overflow <= 1'b1;
    @(posedge sys_clk);
    bus_req.write <= 1'b0;
    t0_state.overflow <= 1'b0;
    rd(tps_pkg::OFS_FLAGS, 8'h01);
    ovf_taken <= 1'b1; cyc(1); ovf_taken <= 1'b0;
    rd(tps_pkg::OFS_FLAGS, 8'h00);
    t0_state.phase_correct <= 1'b1; t0_state.overflow <= 1'b1; cyc(1); t0_state.overflow <= 1'b0;
    rd(tps_pkg::OFS_FLAGS, 8'h00);
    t0_state.bottom_turn <= 1'b1; cyc(1); t0_state.bottom_turn <= 1'b0;
    rd(tps_pkg::OFS_FLAGS, 8'h01);
    cyc(4);
    test_done;
  end
endmodule
